// >>> rtl/smm_decode_defs.vh
`ifndef SMM_DECODE_DEFS_VH
`define SMM_DECODE_DEFS_VH

// ---------------------------------------------------------------
// register map (word-aligned byte offsets on the byte address port)
// ---------------------------------------------------------------
`define REG_SMM_RAM_CONTROL 8'h00
`define REG_EXT_CONTROL     8'h04
`define REG_SHADOW_MAP      8'h08
`define REG_MEMORY_TOP      8'h0C
`define REG_IRQ_STATUS      8'h10
`define REG_IRQ_MASK        8'h14

// ---------------------------------------------------------------
// smm_ram_control fields
// ---------------------------------------------------------------
`define CTL_BASE_SEG_LSB    0
`define CTL_GLOBAL_EN_BIT   3
`define CTL_CLOSE_BIT       5
`define CTL_OPEN_BIT        6
`define CTL_RESET           8'h02
`define COMPAT_SEG_CODE     3'h2

// ---------------------------------------------------------------
// extended control fields
// ---------------------------------------------------------------
`define EXT_HIGH_EN_BIT     0
`define EXT_TOP_EN_BIT      1
`define EXT_TOP_SZ_LSB      2
`define EXT_ERR_BIT         7
`define EXT_RESET           8'h00

// ---------------------------------------------------------------
// address ranges
// ---------------------------------------------------------------
`define SEG_A_BASE          32'h000A0000
`define SEG_B_END           32'h000BFFFF
`define LOW_MEG_END         32'h000FFFFF
`define HIGH_ALIAS_BASE     32'h100A0000
`define HIGH_ALIAS_END      32'h100FFFFF
`define ALIAS_OFFSET        32'h10000000
`define TOP_BLOCK_MIN       32'h00020000
`define CACHE_L2_LIMIT      32'h02000000
`define MEMORY_TOP_RESET    32'h00800000

`endif

// >>> rtl/smm_ram_access_decoder.v
`timescale 1ns/1ns
`include "smm_decode_defs.vh"

module smm_ram_access_decoder #(
  parameter AW = 32
) (
  // clock and reset
  input  wire          clk_i,
  input  wire          resetn_i,
  // register port
  input  wire [7:0]    reg_addr_i,
  input  wire [31:0]   reg_wdata_i,
  input  wire          reg_wr_i,
  input  wire          reg_rd_i,
  output reg  [31:0]   reg_rdata_o,
  // host cycle
  input  wire          host_valid_i,
  input  wire [AW-1:0] host_addr_i,
  input  wire          host_writeback_i,
  input  wire          smm_active_n_i,
  output reg           host_to_dram_o,
  output reg           host_to_pci_o,
  output reg  [AW-1:0] dram_addr_o,
  output reg           cache_l1_o,
  output reg           cache_l2_o,
  // pci master cycle
  input  wire          pci_valid_i,
  input  wire [AW-1:0] pci_addr_i,
  output reg           pci_claim_o,
  // interrupt
  output reg           irq_o
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [7:0]    smm_ram_control_ff;  // base seg, global en, close, open
  reg  [7:0]    ext_control_ff;      // high en, top en, size, error
  reg  [7:0]    shadow_attribute_map_ff; // [2:0] C/D/E shadowed, [3] F suspend/resume
  reg  [AW-1:0] memory_top_ff;       // installed dram size
  reg  [1:0]    irq_status_ff;       // [0] illegal access, [1] pci refused
  reg  [1:0]    irq_mask_ff;         // 1 enables that status bit

  // ---------------------------------------------------------------
  // decoded control fields
  // ---------------------------------------------------------------
  wire          global_smm_ram_enable = smm_ram_control_ff[`CTL_GLOBAL_EN_BIT];
  wire          smm_space_open_bit    = smm_ram_control_ff[`CTL_OPEN_BIT];
  wire          smm_space_close       = smm_ram_control_ff[`CTL_CLOSE_BIT];
  wire [2:0]    compat_base_segment   = smm_ram_control_ff[`CTL_BASE_SEG_LSB+2:`CTL_BASE_SEG_LSB];
  wire          high_mem_smm_enable   = ext_control_ff[`EXT_HIGH_EN_BIT];
  wire          top_block_enable      = ext_control_ff[`EXT_TOP_EN_BIT];
  wire [1:0]    top_block_size        = ext_control_ff[`EXT_TOP_SZ_LSB+1:`EXT_TOP_SZ_LSB];

  // size of the top block in bytes
  function [AW-1:0] block_bytes;
    input [1:0] sz;
    begin
      block_bytes = `TOP_BLOCK_MIN << sz;
    end
  endfunction

  // 64 KB segment index for the low megabyte, A=0 .. F=5
  function [2:0] seg_index;
    input [AW-1:0] a;
    begin
      seg_index = a[18:16] - 3'h2;
    end
  endfunction

  // is this low-megabyte segment usable as extended smm ram
  function seg_usable;
    input [2:0] idx;
    input       en;
    input [7:0] shadow_attribute_map;
    begin
      case (idx)
        3'h0, 3'h1: seg_usable = en;
        3'h2, 3'h3, 3'h4: seg_usable = en & ~shadow_attribute_map[idx - 3'h2];
        3'h5: seg_usable = en & shadow_attribute_map[3];
        default: seg_usable = 1'b0;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // mode and window decode
  // ---------------------------------------------------------------
  wire          compat_mode  = (compat_base_segment == `COMPAT_SEG_CODE) &
                               global_smm_ram_enable;
  wire          high_en      = high_mem_smm_enable & global_smm_ram_enable;
  wire          top_en       = top_block_enable & global_smm_ram_enable;
  wire [AW-1:0] top_size     = block_bytes(top_block_size);
  wire [AW-1:0] top_base     = memory_top_ff - top_size;
  wire          host_active  = ~smm_active_n_i;
  wire          host_ok      = host_active | smm_space_open_bit | host_writeback_i;

  // host address classification
  wire          h_compat_ab  = compat_mode & (host_addr_i >= `SEG_A_BASE) &
                               (host_addr_i <= `SEG_B_END);
  wire          h_in_alias   = (host_addr_i >= `HIGH_ALIAS_BASE) & (host_addr_i <= `HIGH_ALIAS_END);
  wire          h_high_hit   = high_en & h_in_alias &
                               seg_usable(seg_index(host_addr_i), 1'b1, shadow_attribute_map_ff);
  wire [AW-1:0] h_low        = host_addr_i - `ALIAS_OFFSET;
  wire          h_top_hit    = top_en & (host_addr_i >= `ALIAS_OFFSET) &
                               (h_low >= top_base) & (h_low < memory_top_ff);
  wire          h_top_plain  = top_en & (host_addr_i >= top_base) & (host_addr_i < memory_top_ff);
  wire          h_ext_hit    = h_high_hit | h_top_hit;

  // compat mode: a write-back always picks dram; otherwise in smm, dram unless close is set and open is clear
  wire          compat_dram  = host_active ? (smm_space_open_bit | ~smm_space_close |
                               host_writeback_i) : host_writeback_i;

  // pci master classification
  wire          p_compat_ab  = compat_mode & (pci_addr_i >= `SEG_A_BASE) & (pci_addr_i <= `SEG_B_END);
  wire          p_low        = (pci_addr_i >= `SEG_A_BASE) & (pci_addr_i <= `LOW_MEG_END) &
                               high_en & seg_usable(seg_index(pci_addr_i), 1'b1, shadow_attribute_map_ff);
  wire          p_alias      = (pci_addr_i >= `HIGH_ALIAS_BASE) & (pci_addr_i <= `HIGH_ALIAS_END);
  wire          p_top        = top_en & (((pci_addr_i >= top_base) & (pci_addr_i < memory_top_ff)) |
                               ((pci_addr_i >= `ALIAS_OFFSET) & (pci_addr_i - `ALIAS_OFFSET >= top_base) &
                               (pci_addr_i - `ALIAS_OFFSET < memory_top_ff)));
  wire          p_smm        = p_compat_ab | p_low | p_alias | p_top;

  // ---------------------------------------------------------------
  // next-state values for the host path
  // ---------------------------------------------------------------
  reg           nxt_dram;
  reg           nxt_pci;
  reg  [AW-1:0] nxt_addr;
  reg           nxt_l1;
  reg           nxt_l2;
  reg           illegal;

  // host routing decision
  always @* begin
    nxt_dram = 1'b0;
    nxt_pci  = 1'b0;
    nxt_addr = host_addr_i;
    nxt_l1   = 1'b1;
    nxt_l2   = 1'b1;
    illegal  = 1'b0;
    if (host_valid_i) begin
      if (h_compat_ab) begin
        // compatible space is never cacheable
        nxt_dram = compat_dram;
        nxt_pci  = ~compat_dram;
        nxt_l1   = 1'b0;
        nxt_l2   = 1'b0;
      end else if (h_ext_hit) begin
        nxt_addr = h_low;
        nxt_dram = host_ok;
        nxt_pci  = ~host_ok;
        illegal  = ~host_ok;
        nxt_l2   = (memory_top_ff < `CACHE_L2_LIMIT);
      end else if (h_in_alias) begin
        // unconfigured alias parts fall through to pci
        nxt_pci  = 1'b1;
      end else if (h_top_plain) begin
        // carved block is gone from normal memory
        nxt_pci  = 1'b1;
      end else if (host_addr_i < memory_top_ff) begin
        nxt_dram = 1'b1;
      end else begin
        nxt_pci  = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // register and output flops
  // ---------------------------------------------------------------
  wire          rd_status    = reg_rd_i & (reg_addr_i == `REG_IRQ_STATUS);
  wire          pci_refused  = pci_valid_i & p_smm;
  wire [1:0]    events       = {pci_refused, illegal};

  // sequential state; set wins over any clear in the same cycle
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      smm_ram_control_ff      <= `CTL_RESET;
      ext_control_ff          <= `EXT_RESET;
      shadow_attribute_map_ff <= 8'h00;
      memory_top_ff           <= `MEMORY_TOP_RESET;
      irq_status_ff           <= 2'h0;
      irq_mask_ff             <= 2'h0;
      reg_rdata_o             <= 32'h0;
      host_to_dram_o          <= 1'b0;
      host_to_pci_o           <= 1'b0;
      dram_addr_o             <= {AW{1'b0}};
      cache_l1_o              <= 1'b0;
      cache_l2_o              <= 1'b0;
      pci_claim_o             <= 1'b0;
      irq_o                   <= 1'b0;
    end else begin
      // register writes
      if (reg_wr_i) begin
        case (reg_addr_i)
          `REG_SMM_RAM_CONTROL: smm_ram_control_ff <= reg_wdata_i[7:0];
          `REG_SHADOW_MAP:      shadow_attribute_map_ff <= reg_wdata_i[7:0];
          `REG_MEMORY_TOP:      memory_top_ff <= reg_wdata_i[AW-1:0];
          `REG_IRQ_MASK:        irq_mask_ff <= reg_wdata_i[1:0];
          default: ;
        endcase
      end
      // extended control: error bit is write-one-to-clear, sticky
      if (reg_wr_i && reg_addr_i == `REG_EXT_CONTROL)
        ext_control_ff <= {(ext_control_ff[`EXT_ERR_BIT] & ~reg_wdata_i[`EXT_ERR_BIT]) | illegal,
                           reg_wdata_i[6:0]};
      else if (illegal)
        ext_control_ff[`EXT_ERR_BIT] <= 1'b1;
      // interrupt status cleared by read, new events win
      irq_status_ff <= (rd_status ? 2'h0 : irq_status_ff) | events;
      irq_o         <= |(((rd_status ? 2'h0 : irq_status_ff) | events) & irq_mask_ff);
      // read data, one cycle after the strobe only
      if (reg_rd_i) begin
        case (reg_addr_i)
          `REG_SMM_RAM_CONTROL: reg_rdata_o <= {24'h0, smm_ram_control_ff};
          `REG_EXT_CONTROL:     reg_rdata_o <= {24'h0, ext_control_ff};
          `REG_SHADOW_MAP:      reg_rdata_o <= {24'h0, shadow_attribute_map_ff};
          `REG_MEMORY_TOP:      reg_rdata_o <= memory_top_ff;
          `REG_IRQ_STATUS:      reg_rdata_o <= {30'h0, irq_status_ff};
          `REG_IRQ_MASK:        reg_rdata_o <= {30'h0, irq_mask_ff};
          default:              reg_rdata_o <= 32'h0;
        endcase
      end else begin
        reg_rdata_o <= 32'h0;
      end
      // host path, registered one cycle
      host_to_dram_o <= nxt_dram;
      host_to_pci_o  <= nxt_pci;
      dram_addr_o    <= nxt_addr;
      cache_l1_o     <= nxt_l1 & nxt_dram;
      cache_l2_o     <= nxt_l2 & nxt_dram;
      // pci master: claim plain dram only, never smm ram
      pci_claim_o    <= pci_valid_i & ~p_smm & (pci_addr_i < memory_top_ff);
    end
  end

endmodule

// >>> test/smm_decoder_checker.sv
`timescale 1ns/1ns
`include "smm_decode_defs.vh"
// ----------------------------------------------
// port-level checks for the smm address decoder
// ----------------------------------------------
module smm_decoder_checker #(
  parameter AW = 32
) (
  input wire          clk_i,
  input wire          resetn_i,
  input wire          reg_wr_i,
  input wire          reg_rd_i,
  input wire          host_valid_i,
  input wire [AW-1:0] host_addr_i,
  input wire          host_writeback_i,
  input wire          smm_active_n_i,
  input wire          host_to_dram_o,
  input wire          host_to_pci_o,
  input wire [AW-1:0] dram_addr_o,
  input wire          cache_l1_o,
  input wire          cache_l2_o,
  input wire          pci_valid_i,
  input wire [AW-1:0] pci_addr_i,
  input wire          pci_claim_o,
  input wire          irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // host cycle aimed at the high alias
  sequence s_alias_hit;
    host_valid_i && host_addr_i >= `HIGH_ALIAS_BASE && host_addr_i <= `HIGH_ALIAS_END;
  endsequence
  // plain host cycle to a/b outside smm, not a write-back
  sequence s_ab_outside;
    host_valid_i && smm_active_n_i && !host_writeback_i && host_addr_i >= `SEG_A_BASE && host_addr_i <= `SEG_B_END;
  endsequence
  a_alias_translate: assert property (s_alias_hit ##1 host_to_dram_o |-> dram_addr_o == $past(host_addr_i) - `ALIAS_OFFSET)
    else $error("alias address not translated");
  a_ab_to_pci: assert property (s_ab_outside |=> host_to_pci_o && !host_to_dram_o)
    else $error("a/b cycle outside smm not sent to pci");
  a_pci_ab_ignored: assert property (pci_valid_i && pci_addr_i >= `SEG_A_BASE && pci_addr_i <= `SEG_B_END |=> !pci_claim_o)
    else $error("pci master claimed in smm area");
  a_claim_has_cause: assert property (pci_claim_o |-> $past(pci_valid_i))
    else $error("pci claim without a pci cycle");
  a_route_one_hot: assert property (host_valid_i |=> host_to_dram_o != host_to_pci_o)
    else $error("host cycle routed to none or both");
  a_pci_uncached: assert property (host_to_pci_o |-> !cache_l1_o && !cache_l2_o)
    else $error("pci routed cycle marked cacheable");
  a_l2_needs_l1: assert property (cache_l2_o |-> cache_l1_o)
    else $error("l2 cacheable without l1");
  a_error_held: assert property ((irq_o && !reg_wr_i && !reg_rd_i)[*2] |=> irq_o)
    else $error("error interrupt dropped without software");
endmodule

bind smm_ram_access_decoder smm_decoder_checker #(.AW(AW)) smm_decoder_checker_i (
  .clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .host_valid_i(host_valid_i), .host_addr_i(host_addr_i), .host_writeback_i(host_writeback_i),
  .smm_active_n_i(smm_active_n_i), .host_to_dram_o(host_to_dram_o), .host_to_pci_o(host_to_pci_o),
  .dram_addr_o(dram_addr_o), .cache_l1_o(cache_l1_o), .cache_l2_o(cache_l2_o), .pci_valid_i(pci_valid_i),
  .pci_addr_i(pci_addr_i), .pci_claim_o(pci_claim_o), .irq_o(irq_o));

// >>> test/bus_master_model.sv
`timescale 1ns/1ns
// ---------------------------------------
// host cpu and pci bus master stand-in
// ---------------------------------------
module bus_master_model (
  // clock
  input  wire         clk_i,
  // host side
  output logic        host_valid_o,
  output logic [31:0] host_addr_o,
  output logic        host_wb_o,
  output logic        smm_n_o,
  // pci master side
  output logic        pci_valid_o,
  output logic [31:0] pci_addr_o
);
  initial begin
    host_valid_o = 1'b0;
    host_addr_o  = 32'h0;
    host_wb_o    = 1'b0;
    smm_n_o      = 1'b1;
    pci_valid_o  = 1'b0;
    pci_addr_o   = 32'h0;
  end
  // one host cycle; address inverted on release so a stale value never looks valid
  task host(input logic [31:0] a, input logic sn, input logic wb);
    @(posedge clk_i);
    host_valid_o <= 1'b1;
    host_addr_o  <= a;
    host_wb_o    <= wb;
    smm_n_o      <= sn;
    @(posedge clk_i);
    host_valid_o <= 1'b0;
    host_addr_o  <= ~a;
    #1;
  endtask
  // one pci master cycle, same spacing as the host
  task pci(input logic [31:0] a);
    @(posedge clk_i);
    pci_valid_o <= 1'b1;
    pci_addr_o  <= a;
    @(posedge clk_i);
    pci_valid_o <= 1'b0;
    pci_addr_o  <= ~a;
    #1;
  endtask
endmodule

// >>> test/smm_ram_access_decoder_tb.sv
`timescale 1ns/1ns
`include "smm_decode_defs.vh"
module smm_ram_access_decoder_tb;
  // ---------------------------------------
  // stimulus, wiring and score
  // ---------------------------------------
  localparam logic [31:0] DR = 32'h2; // routed to dram
  localparam logic [31:0] PC = 32'h1; // routed to pci
  logic        clk_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, a;
  wire  [31:0] reg_rdata_o, dram_addr_o, host_addr_i, pci_addr_i;
  wire         host_valid_i, host_writeback_i, smm_active_n_i, pci_valid_i, host_to_dram_o;
  wire         host_to_pci_o, cache_l1_o, cache_l2_o, pci_claim_o, irq_o;
  int          miscompares = 0, comparisons = 0;
  always #5 clk_i = ~clk_i;
  smm_ram_access_decoder smm_ram_access_decoder_i (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .host_valid_i(host_valid_i), .host_addr_i(host_addr_i), .host_writeback_i(host_writeback_i),
    .smm_active_n_i(smm_active_n_i), .host_to_dram_o(host_to_dram_o), .host_to_pci_o(host_to_pci_o),
    .dram_addr_o(dram_addr_o), .cache_l1_o(cache_l1_o), .cache_l2_o(cache_l2_o), .pci_valid_i(pci_valid_i),
    .pci_addr_i(pci_addr_i), .pci_claim_o(pci_claim_o), .irq_o(irq_o));
  bus_master_model bus_master_model_i (.clk_i(clk_i), .host_valid_o(host_valid_i), .host_addr_o(host_addr_i),
    .host_wb_o(host_writeback_i), .smm_n_o(smm_active_n_i), .pci_valid_o(pci_valid_i), .pci_addr_o(pci_addr_i));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // register write: strobe for one cycle
  task wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= ad;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // register read: data stands only in the cycle after the strobe
  task rd(input logic [7:0] ad, input logic [31:0] exp);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= ad;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask
  // host cycle, then compare the {dram, pci} routing pair
  task route(input logic [31:0] ad, input logic sn, input logic wb, input logic [31:0] exp);
    bus_master_model_i.host(ad, sn, wb);
    chk({30'h0, host_to_dram_o, host_to_pci_o}, exp);
  endtask
  task results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    #50000;
    miscompares++;
    results;
  end
  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(`REG_SMM_RAM_CONTROL, 32'h02);
    rd(`REG_MEMORY_TOP, `MEMORY_TOP_RESET);
    rd(8'h18, 32'h0);
    wr(`REG_SMM_RAM_CONTROL, 32'h0A);
    route(`SEG_A_BASE, 1'b1, 1'b0, PC);
    route(`SEG_B_END, 1'b0, 1'b0, DR);
    wr(`REG_SMM_RAM_CONTROL, 32'h2A);
    route(`SEG_A_BASE, 1'b0, 1'b0, PC);
    bus_master_model_i.pci(`SEG_A_BASE);
    chk(pci_claim_o, 32'h0);
    $display("compatible test done");
    wr(`REG_SMM_RAM_CONTROL, 32'h0A);
    wr(`REG_EXT_CONTROL, 32'h01);
    route(`HIGH_ALIAS_BASE, 1'b0, 1'b0, DR);
    chk(dram_addr_o, `SEG_A_BASE);
    chk({cache_l1_o, cache_l2_o}, 32'h3);
    route(`HIGH_ALIAS_BASE, 1'b1, 1'b0, PC);
    chk(irq_o, 32'h0);
    rd(`REG_IRQ_STATUS, 32'h3);
    wr(`REG_IRQ_MASK, 32'h1);
    route(32'h100B0000, 1'b1, 1'b0, PC);
    chk(irq_o, 32'h1);
    rd(`REG_EXT_CONTROL, 32'h81);
    route(`HIGH_ALIAS_BASE, 1'b0, 1'b0, DR);
    rd(`REG_EXT_CONTROL, 32'h81);
    rd(`REG_IRQ_STATUS, 32'h1);
    @(posedge clk_i);
    #1 chk(irq_o, 32'h0);
    wr(`REG_EXT_CONTROL, 32'h81);
    rd(`REG_EXT_CONTROL, 32'h01);
    route(32'h100B0000, 1'b1, 1'b1, DR);
    wr(`REG_SMM_RAM_CONTROL, 32'h4A);
    route(32'h100E0000, 1'b1, 1'b0, DR);
    bus_master_model_i.pci(`HIGH_ALIAS_BASE);
    chk(pci_claim_o, 32'h0);
    wr(`REG_SHADOW_MAP, 32'h01);
    route(32'h100C0000, 1'b0, 1'b0, PC);
    route(32'h100F0000, 1'b0, 1'b0, PC);
    wr(`REG_SHADOW_MAP, 32'h08);
    route(32'h100F0000, 1'b0, 1'b0, DR);
    $display("extended high memory test done");
    for (int s = 0; s < 4; s++) begin
      wr(`REG_EXT_CONTROL, 32'(2 | (s << 2)));
      a = `ALIAS_OFFSET + `MEMORY_TOP_RESET - (`TOP_BLOCK_MIN << s);
      route(a, 1'b0, 1'b0, DR);
      chk(dram_addr_o, a - `ALIAS_OFFSET);
      route(a - 32'h1, 1'b0, 1'b0, PC);
    end
    wr(`REG_SMM_RAM_CONTROL, 32'h42);
    route(a, 1'b0, 1'b0, PC);
    wr(`REG_SMM_RAM_CONTROL, 32'h0A);
    wr(`REG_MEMORY_TOP, 32'h04000000);
    wr(`REG_EXT_CONTROL, 32'h02);
    route(32'h13FE0000, 1'b0, 1'b0, DR);
    chk({cache_l1_o, cache_l2_o}, 32'h2);
    bus_master_model_i.pci(32'h03FE0000);
    chk(pci_claim_o, 32'h0);
    bus_master_model_i.pci(32'h00100000);
    chk(pci_claim_o, 32'h1);
    $display("top block test done");
    results;
  end
endmodule
